// ===== aht_pkg.sv
`default_nettype none
package aht_pkg;
    localparam int NCH      = 4;
    localparam int CAUSE_W  = 4;
    localparam int SEL_W    = 16;
    localparam int NEV      = 16;
    localparam int ADDR_W   = 8;
    localparam int SWT_W    = 2;
    localparam int ENA_LSB  = 4;
    // byte offsets on the register bus
    localparam logic [7:0] OFF_SEL  = 8'h00;
    localparam logic [7:0] OFF_SWT  = 8'h04;
    localparam logic [7:0] OFF_ENA  = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    // reset values
    localparam logic [15:0] SEL_RESET = 16'h0000;
    localparam logic [1:0]  SWT_RESET = 2'h0;
    localparam logic [3:0]  ENA_RESET = 4'h0;
    // status layout
    localparam int STAT_PEND_LSB = 0;
    localparam int STAT_FLAG_LSB = 4;
    // event vector index equals cause code
    localparam int EV_TP_UM_BASE = 0;
    localparam int EV_TP_M_BASE  = 4;
    localparam int EV_CAPTURE_UNIT_ZERO       = 8;
    localparam int EV_CAPTURE_UNIT_ONE       = 9;
    localparam int EV_GEC_OVF    = 10;
    localparam int EV_CAPTURE_UNIT_FIFTEEN      = 11;
    localparam int EV_ET16       = 12;
    localparam int EV_ET17       = 13;
    localparam int EV_SW0        = 14;
    localparam int EV_SW1        = 15;
endpackage
`default_nettype wire

// ===== aht_trig_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aht_trig_if;
    logic [15:0] cause_sel;
    logic [3:0]  chan_en;
    logic [15:0] events;
    logic        fetch_pulse;
    logic [3:0]  pending;
    logic [3:0]  req_flag;
    logic [3:0]  conv_start;
    modport ctrl (output cause_sel, output chan_en, output events, output fetch_pulse,
                  input pending, input req_flag, input conv_start);
    modport core (input cause_sel, input chan_en, input events, input fetch_pulse,
                  output pending, output req_flag, output conv_start);
endinterface
`default_nettype wire

// ===== aht_trig_core.sv
`timescale 1ns/1ps
`default_nettype none
module aht_trig_core (
    // clock and reset
    input wire logic   clk_i,
    input wire logic   rst_i,
    // selector state and results
    aht_trig_if.core   tif
);
    genvar ch;
    generate
        for (ch = 0; ch < aht_pkg::NCH; ch++) begin : g_ch
            logic [3:0] code;
            logic       en;
            logic       hit;
            logic       pend_reg;
            logic       flag_reg;
            logic       start_reg;

            assign code = tif.cause_sel[ch*aht_pkg::CAUSE_W +: aht_pkg::CAUSE_W];
            assign en   = tif.chan_en[ch];
            assign hit  = en & tif.events[code];

            // a hit in the fetch-pulse cycle goes straight into the flag, so none is lost
            always_ff @(posedge clk_i) begin
                if (rst_i || !en) begin
                    pend_reg <= 1'b0;
                end else if (tif.fetch_pulse) begin
                    pend_reg <= 1'b0;
                end else if (hit) begin
                    pend_reg <= 1'b1;
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    flag_reg <= 1'b0;
                end else begin
                    flag_reg <= tif.fetch_pulse & en & (pend_reg | hit);
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    start_reg <= 1'b0;
                end else begin
                    start_reg <= flag_reg;
                end
            end

            assign tif.pending[ch]    = pend_reg;
            assign tif.req_flag[ch]   = flag_reg;
            assign tif.conv_start[ch] = start_reg;

            sequence s_flag;
                flag_reg;
            endsequence
            sequence s_start_next;
                ##1 start_reg;
            endsequence

            property p_flag_to_start;
                @(posedge clk_i) disable iff (rst_i) s_flag |-> s_start_next;
            endproperty
            a_flag_to_start: assert property (p_flag_to_start)
                else $error("conversion start did not follow request flag");

            property p_flag_on_fetch;
                @(posedge clk_i) disable iff (rst_i) flag_reg |-> $past(tif.fetch_pulse);
            endproperty
            a_flag_on_fetch: assert property (p_flag_on_fetch)
                else $error("request flag set without a fetch pulse");

            property p_hit_flags;
                @(posedge clk_i) disable iff (rst_i) (hit && tif.fetch_pulse) |=> flag_reg;
            endproperty
            a_hit_flags: assert property (p_hit_flags)
                else $error("selected event at fetch pulse not flagged");

            property p_disabled_quiet;
                @(posedge clk_i) disable iff (rst_i) !en |=> (!flag_reg && !pend_reg);
            endproperty
            a_disabled_quiet: assert property (p_disabled_quiet)
                else $error("disabled channel raised a request");
        end
    endgenerate
endmodule
`default_nettype wire

// ===== aht_top.sv
`timescale 1ns/1ps
`default_nettype none
module aht_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // peripheral event pulses
    input  wire logic [3:0]  timer_pair_uf_match_i,
    input  wire logic [3:0]  timer_pair_match_i,
    input  wire logic        capture_unit_zero_i,
    input  wire logic        capture_unit_one_i,
    input  wire logic        general_event_counter_ovf_i,
    input  wire logic        capture_unit_fifteen_i,
    input  wire logic        event_timer_sixteen_i,
    input  wire logic        event_timer_seventeen_i,
    // cpu timing
    input  wire logic        fetch_timing_pulse_i,
    // conversion requests, channels 12..15
    output logic [3:0]       req_flag_o,
    output logic [3:0]       conv_start_o
);
    logic [15:0] sel_reg;
    logic [1:0]  swt_reg;
    logic [1:0]  swt_prev_reg;
    logic [3:0]  ena_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] rdata_next;
    logic        req;
    logic        wr;
    logic [1:0]  sw_edge;

    aht_trig_if tif ();

    assign req = cyc_i & stb_i;
    // writes land on the edge where ack is sampled high
    assign wr  = req & we_i & ack_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg <= aht_pkg::SEL_RESET;
        end else if (wr && adr_i == aht_pkg::OFF_SEL && sel_i[1:0] == 2'h3) begin
            sel_reg <= dat_i[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swt_reg <= aht_pkg::SWT_RESET;
        end else if (wr && adr_i == aht_pkg::OFF_SWT && sel_i[0]) begin
            swt_reg <= dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ena_reg <= aht_pkg::ENA_RESET;
        end else if (wr && adr_i == aht_pkg::OFF_ENA && sel_i[0]) begin
            ena_reg <= dat_i[aht_pkg::ENA_LSB +: 4];
        end
    end

    // bits stay set until software clears them, so only the rise counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swt_prev_reg <= aht_pkg::SWT_RESET;
        end else begin
            swt_prev_reg <= swt_reg;
        end
    end
    assign sw_edge = swt_reg & ~swt_prev_reg;

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (adr_i)
            aht_pkg::OFF_SEL:  rdata_next[15:0] = sel_reg;
            aht_pkg::OFF_SWT:  rdata_next[1:0] = swt_reg;
            aht_pkg::OFF_ENA:  rdata_next[aht_pkg::ENA_LSB +: 4] = ena_reg;
            aht_pkg::OFF_STAT: begin
                rdata_next[aht_pkg::STAT_PEND_LSB +: 4] = tif.pending;
                rdata_next[aht_pkg::STAT_FLAG_LSB +: 4] = tif.req_flag;
            end
            default:           rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (req && !ack_reg) begin
            dat_reg <= rdata_next;
        end
    end

    always_comb begin
        tif.events = 16'h0000;
        tif.events[aht_pkg::EV_TP_UM_BASE +: 4] = timer_pair_uf_match_i;
        tif.events[aht_pkg::EV_TP_M_BASE +: 4]  = timer_pair_match_i;
        tif.events[aht_pkg::EV_CAPTURE_UNIT_ZERO]    = capture_unit_zero_i;
        tif.events[aht_pkg::EV_CAPTURE_UNIT_ONE]    = capture_unit_one_i;
        tif.events[aht_pkg::EV_GEC_OVF] = general_event_counter_ovf_i;
        tif.events[aht_pkg::EV_CAPTURE_UNIT_FIFTEEN]   = capture_unit_fifteen_i;
        tif.events[aht_pkg::EV_ET16]    = event_timer_sixteen_i;
        tif.events[aht_pkg::EV_ET17]    = event_timer_seventeen_i;
        tif.events[aht_pkg::EV_SW0]     = sw_edge[0];
        tif.events[aht_pkg::EV_SW1]     = sw_edge[1];
    end

    assign tif.cause_sel   = sel_reg;
    assign tif.chan_en     = ena_reg;
    assign tif.fetch_pulse = fetch_timing_pulse_i;

    aht_trig_core u_core (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tif   (tif)
    );

    assign dat_o        = dat_reg;
    assign ack_o        = ack_reg;
    assign req_flag_o   = tif.req_flag;
    assign conv_start_o = tif.conv_start;

    property p_sel_reset;
        @(posedge clk_i) rst_i |=> (sel_reg == 16'h0000);
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("selector not cleared by reset");

    property p_partial_ignored;
        @(posedge clk_i) disable iff (rst_i)
            (wr && adr_i == aht_pkg::OFF_SEL && sel_i[1:0] != 2'h3) |=> $stable(sel_reg);
    endproperty
    a_partial_ignored: assert property (p_partial_ignored)
        else $error("partial write changed selector");

    property p_full_write;
        @(posedge clk_i) disable iff (rst_i)
            (wr && adr_i == aht_pkg::OFF_SEL && sel_i[1:0] == 2'h3)
            |=> (sel_reg == $past(dat_i[15:0]));
    endproperty
    a_full_write: assert property (p_full_write)
        else $error("full write did not load selector");

    property p_sw_edge_once;
        @(posedge clk_i) disable iff (rst_i) sw_edge[0] |=> !sw_edge[0];
    endproperty
    a_sw_edge_once: assert property (p_sw_edge_once)
        else $error("software trigger fired twice without a new rise");

    // bus answer: one wait state, then a single-cycle ack
    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i) (req && !ack_reg) |=> ack_reg;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("register access not acknowledged");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) ack_reg |=> !ack_reg;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge held longer than one cycle");

    property p_sel_readback;
        @(posedge clk_i) disable iff (rst_i)
            (ack_reg && !we_i && adr_i == aht_pkg::OFF_SEL)
            |-> (dat_reg == {16'h0000, sel_reg});
    endproperty
    a_sel_readback: assert property (p_sel_readback)
        else $error("selector read returned a different word");

    property p_ena_write;
        @(posedge clk_i) disable iff (rst_i)
            (wr && adr_i == aht_pkg::OFF_ENA && sel_i[0])
            |=> (ena_reg == $past(dat_i[aht_pkg::ENA_LSB +: 4]));
    endproperty
    a_ena_write: assert property (p_ena_write)
        else $error("enable write did not land");

    property p_flag_needs_enable;
        @(posedge clk_i) disable iff (rst_i)
            (tif.req_flag != 4'h0) |-> ((tif.req_flag & ~$past(ena_reg)) == 4'h0);
    endproperty
    a_flag_needs_enable: assert property (p_flag_needs_enable)
        else $error("request flag on a disabled channel");

    // a write that raises software bit 0, then the edge one cycle later
    sequence s_sw0_raise;
        wr && adr_i == aht_pkg::OFF_SWT && sel_i[0] && dat_i[0] && !swt_reg[0];
    endsequence
    sequence s_sw0_edge_next;
        ##1 sw_edge[0];
    endsequence

    property p_sw_raise_edge;
        @(posedge clk_i) disable iff (rst_i) s_sw0_raise |-> s_sw0_edge_next;
    endproperty
    a_sw_raise_edge: assert property (p_sw_raise_edge)
        else $error("software trigger rise gave no edge");

    // rewriting a bit that is already one must not fire again
    property p_sw_held_quiet;
        @(posedge clk_i) disable iff (rst_i)
            (wr && adr_i == aht_pkg::OFF_SWT && sel_i[0] && dat_i[0] && swt_reg[0])
            |=> !sw_edge[0];
    endproperty
    a_sw_held_quiet: assert property (p_sw_held_quiet)
        else $error("software trigger fired on a rewrite of one");

    property p_sw1_edge_once;
        @(posedge clk_i) disable iff (rst_i) sw_edge[1] |=> !sw_edge[1];
    endproperty
    a_sw1_edge_once: assert property (p_sw1_edge_once)
        else $error("software trigger 1 fired twice without a new rise");
endmodule
`default_nettype wire

// ===== aht_event_src.sv
`timescale 1ns/1ps
`default_nettype none
module aht_event_src (
    // clock and command
    input  wire logic       clk_i,
    input  wire logic       fire_i,
    input  wire logic [3:0] code_i,
    // event pulses, bit index equals cause code
    output logic [13:0]     ev_o
);
    // strictly one cycle per command: a held level would re-trigger
    always_ff @(posedge clk_i) begin
        ev_o <= fire_i ? (14'h0001 << code_i) : 14'h0000;
    end
endmodule
`default_nettype wire

// ===== tb_adc1_hard_trigger_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc1_hard_trigger_select;
    logic        clk_i      = 1'b0;
    logic        rst_i      = 1'b1;
    logic        cyc_i      = 1'b0;
    logic        stb_i      = 1'b0;
    logic        we_i       = 1'b0;
    logic [7:0]  adr_i      = 8'h00;
    logic [3:0]  sel_i      = 4'h0;
    logic [31:0] dat_i      = 32'h0;
    logic        fire       = 1'b0;
    logic [3:0]  code       = 4'h0;
    logic        fetch      = 1'b0;
    logic        fetch_prev = 1'b0;
    logic [1:0]  fcnt       = 2'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [13:0] ev;
    logic [3:0]  req_flag_o;
    logic [3:0]  conv_start_o;
    logic [31:0] rd;
    int          n_errors   = 0;
    int          cmp_count  = 0;

    always #5 clk_i = ~clk_i;
    // sparse fetch pulses so an event outside a fetch cycle has to wait for the next one
    always @(posedge clk_i) begin
        fcnt <= fcnt + 2'h1;
        fetch <= (fcnt == 2'h3);
        fetch_prev <= fetch;
    end

    aht_event_src aht_event_src_i (.clk_i(clk_i), .fire_i(fire), .code_i(code), .ev_o(ev));
    aht_top aht_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .timer_pair_uf_match_i(ev[3:0]), .timer_pair_match_i(ev[7:4]),
        .capture_unit_zero_i(ev[8]), .capture_unit_one_i(ev[9]),
        .general_event_counter_ovf_i(ev[10]), .capture_unit_fifteen_i(ev[11]),
        .event_timer_sixteen_i(ev[12]), .event_timer_seventeen_i(ev[13]),
        .fetch_timing_pulse_i(fetch), .req_flag_o(req_flag_o), .conv_start_o(conv_start_o));

    task automatic test_done();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        i = 0;
        // ack is looked at as the edge samples it; data is taken at that same edge
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 20);
        if (ack_o !== 1'b1) begin
            n_errors++;
            test_done();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic pulse(input logic [3:0] c);
        @(posedge clk_i);
        fire <= 1'b1;
        code <= c;
        @(posedge clk_i);
        fire <= 1'b0;
        #1;
    endtask

    task automatic expect_req(input int n, input logic hit);
        int i;
        for (i = 0; i < 12 && req_flag_o === 4'h0; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk("req_flag", hit ? (32'h1 << n) : 32'h0, {28'h0, req_flag_o});
        if (hit && req_flag_o === 4'h0) begin
            test_done();
        end
        if (hit) begin
            chk("fetch_align", 32'h1, {31'h0, fetch_prev});
            @(posedge clk_i);
            #1;
            chk("conv_start", 32'h1 << n, {28'h0, conv_start_o});
        end
    endtask

    task automatic t_reset();
        wb(1'b0, aht_pkg::OFF_SEL, 4'hf, 32'h0);
        chk("sel_reset", 32'h0, rd);
        wb(1'b0, aht_pkg::OFF_ENA, 4'hf, 32'h0);
        chk("ena_reset", 32'h0, rd);
    endtask

    task automatic t_access();
        wb(1'b1, aht_pkg::OFF_SEL, 4'hf, 32'h0000a5c3);
        wb(1'b0, aht_pkg::OFF_SEL, 4'hf, 32'h0);
        chk("sel_full", 32'ha5c3, rd);
        wb(1'b1, aht_pkg::OFF_SEL, 4'h1, 32'h0000ffff);
        wb(1'b0, aht_pkg::OFF_SEL, 4'hf, 32'h0);
        chk("sel_partial", 32'ha5c3, rd);
        wb(1'b0, 8'h40, 4'hf, 32'h0);
        chk("unmapped", 32'h0, rd);
        // a reset in mid-run must clear a loaded selector
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, aht_pkg::OFF_SEL, 4'hf, 32'h0);
        chk("sel_midrun_reset", 32'h0, rd);
    endtask

    task automatic t_codes();
        int c;
        logic [15:0] s;
        wb(1'b1, aht_pkg::OFF_ENA, 4'hf, 32'hf0);
        for (c = 0; c < 14; c++) begin
            s = 16'hffff;
            s[4*(c%4) +: 4] = c[3:0];
            wb(1'b1, aht_pkg::OFF_SEL, 4'hf, {16'h0, s});
            pulse(c[3:0]);
            expect_req(c % 4, 1'b1);
        end
    endtask

    task automatic t_disable();
        wb(1'b1, aht_pkg::OFF_ENA, 4'hf, 32'he0);
        wb(1'b1, aht_pkg::OFF_SEL, 4'hf, 32'hfff8);
        pulse(4'h8);
        expect_req(0, 1'b0);
    endtask

    task automatic t_status();
        int i;
        wb(1'b1, aht_pkg::OFF_ENA, 4'hf, 32'h10);
        wb(1'b1, aht_pkg::OFF_SEL, 4'hf, 32'hfff8);
        i = 0;
        // line up on a fetch pulse so the event waits one cycle in pending for the next one
        do begin
            @(posedge clk_i);
            i++;
        end while (fetch !== 1'b1 && i < 8);
        pulse(4'h8);
        wb(1'b0, aht_pkg::OFF_STAT, 4'hf, 32'h0);
        chk("stat_pending", 32'h1, rd);
        wb(1'b0, aht_pkg::OFF_STAT, 4'hf, 32'h0);
        chk("stat_cleared", 32'h0, rd);
    endtask

    task automatic t_soft();
        int b;
        wb(1'b1, aht_pkg::OFF_ENA, 4'hf, 32'hf0);
        wb(1'b1, aht_pkg::OFF_SEL, 4'hf, 32'h00fe);
        for (b = 0; b < 2; b++) begin
            wb(1'b1, aht_pkg::OFF_SWT, 4'hf, 32'h1 << b);
            expect_req(b, 1'b1);
            wb(1'b1, aht_pkg::OFF_SWT, 4'hf, 32'h1 << b);
            expect_req(b, 1'b0);
            wb(1'b1, aht_pkg::OFF_SWT, 4'hf, 32'h0);
            wb(1'b1, aht_pkg::OFF_SWT, 4'hf, 32'h1 << b);
            expect_req(b, 1'b1);
            wb(1'b1, aht_pkg::OFF_SWT, 4'hf, 32'h0);
        end
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_access();
        t_codes();
        t_disable();
        t_status();
        t_soft();
        test_done();
    end
endmodule
`default_nettype wire
